/* File: src/core_subset_pkg.sv */
// Constants, opcodes and register map shared by the instruction subset core.
package core_subset_pkg;

    // Instruction word layout and opcode prefixes.
    localparam logic [7:0]  BRANCH_OV_OPC   = 8'he4;
    localparam logic [7:0]  BRANCH_Z_OPC    = 8'he0;
    localparam logic [6:0]  INVOKE_OPC      = 7'h76;
    localparam logic [3:0]  INVOKE_HI_OPC   = 4'hf;
    localparam logic [6:0]  CLEAR_OPC       = 7'h35;
    localparam logic [15:0] WDT_CLEAR_OPC   = 16'h0004;
    localparam logic [5:0]  COMPL_OPC       = 6'h07;
    localparam logic [6:0]  CMP_SKIP_OPC    = 7'h31;
    localparam logic [15:0] NOP_WORD        = 16'h0000;

    // Addressing: access bank split point and indexed literal offset limit.
    localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
    localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;
    localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
    localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;

    // Flag bit positions in the flags register.
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam int          FLAG_N          = 4;

    // Return stack.
    localparam int          STACK_DEPTH     = 31;
    localparam logic [20:0] RETURN_STEP     = 21'h000002;
    localparam logic [20:0] PC_STEP         = 21'h000002;

    // Avalon register word offsets (byte address = 4 * index).
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_PC          = 4'h1;
    localparam logic [3:0]  REG_CORE        = 4'h2;
    localparam logic [3:0]  REG_SHADOW      = 4'h3;
    localparam logic [3:0]  REG_STACK       = 4'h4;
    localparam logic [3:0]  REG_WDT         = 4'h5;
    localparam logic [3:0]  REG_INDEX       = 4'h6;

    // Control register fields and reset values.
    localparam int          CTRL_RUN        = 0;
    localparam int          CTRL_EXT        = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h1;
    localparam int          WDT_EXP_BIT     = 24;
    localparam int          WDT_SLP_BIT     = 25;

    // Executed operation after decode.
    typedef enum logic [3:0] {
        OP_NOP                  = 4'h0,
        OP_BRANCH_ON_OVERFLOW   = 4'h1,
        OP_BRANCH_ON_ZERO_FLAG  = 4'h2,
        OP_INVOKE               = 4'h3,
        OP_REGISTER_CLEAR       = 4'h4,
        OP_WATCHDOG_CLEAR       = 4'h5,
        OP_REGISTER_COMPLEMENT  = 4'h6,
        OP_COMPARE_SKIP_EQUAL   = 4'h7
    } op_e;

endpackage : core_subset_pkg

/* File: src/cpu_instruction_subset_exec.sv */
// Four-phase execution core for a subset of an 8-bit instruction set.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps

module cpu_instruction_subset_exec (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Program memory, combinational read.
    output logic      [20:0] prog_addr_o,
    input  wire logic [15:0] prog_data_i,
    // Banked data memory, combinational read.
    output logic      [11:0] data_addr_o,
    input  wire logic [7:0]  data_rdata_i,
    output logic      [7:0]  data_wdata_o,
    output logic             data_we_o
);

    // Phase counter and instruction state.
    localparam int STACK_DEPTH = core_subset_pkg::STACK_DEPTH;
    logic [1:0]  phase_r;
    logic        running;
    logic [15:0] ir_r;
    logic        exec_valid_r;
    logic [20:0] program_counter_r;
    logic [7:0]  accum_r;
    logic [4:0]  flags_r;
    logic [3:0]  bank_select_reg_r;
    logic [7:0]  accumulator_shadow_r;
    logic [4:0]  flags_shadow_r;
    logic [3:0]  bank_select_shadow_r;
    logic [20:0] stack_mem [STACK_DEPTH];
    logic [4:0]  stack_ptr_r;
    logic [20:0] stack_top_r;
    logic [7:0]  wdt_count_r;
    logic [15:0] wdt_post_r;
    logic        watchdog_expired_n_r;
    logic        sleep_entered_n_r;
    logic [1:0]  ctrl_r;
    logic [11:0] index_base_r;
    logic [7:0]  operand_r;
    logic [7:0]  result_r;
    logic        equal_r;
    logic [11:0] data_addr_r;
    logic [7:0]  data_wdata_r;
    logic        data_we_r;
    logic        ack_r;
    logic [31:0] readdata_r;

    // Decoded view of the current instruction.
    core_subset_pkg::op_e op;
    logic        access_bit;
    logic        dest_bit;
    logic        save_bit;
    logic [7:0]  reg_field;
    logic [20:0] branch_target;
    logic        branch_taken;
    logic        flush;
    logic        phase1;
    logic        phase2;
    logic        phase3;
    logic        phase4;
    logic        bus_req;
    logic        bus_write;

    // Opcode decode; everything outside the subset, including a stray 1111 word, is a no-op.
    function automatic core_subset_pkg::op_e decode_op(input logic [15:0] word);
        core_subset_pkg::op_e res;
        res = core_subset_pkg::OP_NOP;
        if (word[15:8] == core_subset_pkg::BRANCH_OV_OPC) begin
            res = core_subset_pkg::OP_BRANCH_ON_OVERFLOW;
        end else if (word[15:8] == core_subset_pkg::BRANCH_Z_OPC) begin
            res = core_subset_pkg::OP_BRANCH_ON_ZERO_FLAG;
        end else if (word[15:9] == core_subset_pkg::INVOKE_OPC) begin
            res = core_subset_pkg::OP_INVOKE;
        end else if (word[15:9] == core_subset_pkg::CLEAR_OPC) begin
            res = core_subset_pkg::OP_REGISTER_CLEAR;
        end else if (word == core_subset_pkg::WDT_CLEAR_OPC) begin
            res = core_subset_pkg::OP_WATCHDOG_CLEAR;
        end else if (word[15:10] == core_subset_pkg::COMPL_OPC) begin
            res = core_subset_pkg::OP_REGISTER_COMPLEMENT;
        end else if (word[15:9] == core_subset_pkg::CMP_SKIP_OPC) begin
            res = core_subset_pkg::OP_COMPARE_SKIP_EQUAL;
        end
        return res;
    endfunction : decode_op

    // Data address for a byte operand under the three addressing modes.
    function automatic logic [11:0] operand_addr(input logic [7:0] f, input logic a,
                                                 input logic ext, input logic [3:0] bank,
                                                 input logic [11:0] base);
        logic [11:0] res;
        res = {bank, f};
        if (!a && ext && f <= core_subset_pkg::INDEXED_LIMIT) begin
            res = base + {4'h0, f};
        end else if (!a) begin
            res = (f < core_subset_pkg::ACCESS_SPLIT) ? {core_subset_pkg::ACCESS_LO_BANK, f}
                                                      : {core_subset_pkg::ACCESS_HI_BANK, f};
        end
        return res;
    endfunction : operand_addr

    // Decode and branch arithmetic; a flushed slot executes as a no-op.
    assign op            = exec_valid_r ? decode_op(ir_r) : core_subset_pkg::OP_NOP;
    assign access_bit    = ir_r[8];
    assign dest_bit      = ir_r[9];
    assign save_bit      = ir_r[8];
    assign reg_field     = ir_r[7:0];
    assign branch_target = program_counter_r + {{12{ir_r[7]}}, ir_r[7:0], 1'b0};
    assign branch_taken  = (op == core_subset_pkg::OP_BRANCH_ON_OVERFLOW &&
                            flags_r[core_subset_pkg::FLAG_OV]) ||
                           (op == core_subset_pkg::OP_BRANCH_ON_ZERO_FLAG &&
                            flags_r[core_subset_pkg::FLAG_Z]);
    // Taken branches, invokes and equal compares throw away the word fetched this cycle.
    assign flush         = branch_taken || op == core_subset_pkg::OP_INVOKE ||
                           (op == core_subset_pkg::OP_COMPARE_SKIP_EQUAL && equal_r);
    assign running       = ctrl_r[core_subset_pkg::CTRL_RUN];
    assign phase1        = running && phase_r == 2'h0;
    assign phase2        = running && phase_r == 2'h1;
    assign phase3        = running && phase_r == 2'h2;
    assign phase4        = running && phase_r == 2'h3;
    assign bus_req       = avs_read_i || avs_write_i;
    assign bus_write     = avs_write_i && ack_r;

    // Four clock phases make one instruction cycle; clearing run freezes the core in place.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phase_r <= 2'h0;
        end else if (running) begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // Fetch in phase four; the word after a flush is kept only as a no-op slot.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ir_r         <= core_subset_pkg::NOP_WORD;
            exec_valid_r <= 1'b0;
        end else if (phase4) begin
            ir_r         <= prog_data_i;
            exec_valid_r <= !flush;
        end
    end

    // Program counter: step per fetch, or jump in phase four.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            program_counter_r <= 21'h000000;
        end else if (phase4) begin
            if (op == core_subset_pkg::OP_INVOKE) begin
                // The second word sits at the fetch address during this phase.
                program_counter_r <= {prog_data_i[11:0], reg_field, 1'b0};
            end else if (branch_taken) begin
                program_counter_r <= branch_target;
            end else begin
                program_counter_r <= program_counter_r + core_subset_pkg::PC_STEP;
            end
        end
    end

    // Return stack push in phase three; the counter already points at the second word.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stack_ptr_r <= 5'h00;
            stack_top_r <= 21'h000000;
        end else if (phase3 && op == core_subset_pkg::OP_INVOKE) begin
            stack_top_r <= program_counter_r + core_subset_pkg::RETURN_STEP;
            if (stack_ptr_r < 5'(STACK_DEPTH)) begin
                stack_ptr_r <= stack_ptr_r + 5'h01;
            end
        end
    end

    // Stack storage; an overflowing push overwrites the top slot, STACK_DEPTH-1.
    always_ff @(posedge ref_clk_i) begin
        if (phase3 && op == core_subset_pkg::OP_INVOKE) begin
            if (stack_ptr_r < 5'(STACK_DEPTH)) begin
                stack_mem[stack_ptr_r] <= program_counter_r + core_subset_pkg::RETURN_STEP;
            end else begin
                stack_mem[STACK_DEPTH-1] <= program_counter_r + core_subset_pkg::RETURN_STEP;
            end
        end
    end

    // Fast-save shadows are written only when the save bit is set.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            accumulator_shadow_r <= 8'h00;
            flags_shadow_r       <= 5'h00;
            bank_select_shadow_r <= 4'h0;
        end else if (phase3 && op == core_subset_pkg::OP_INVOKE && save_bit) begin
            accumulator_shadow_r <= accum_r;
            flags_shadow_r       <= flags_r;
            bank_select_shadow_r <= bank_select_reg_r;
        end
    end

    // Operand address is set up in phase one so it is steady when read in phase two.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_addr_r <= 12'h000;
        end else if (phase1) begin
            data_addr_r <= operand_addr(reg_field, access_bit,
                                        ctrl_r[core_subset_pkg::CTRL_EXT],
                                        bank_select_reg_r, index_base_r);
        end
    end

    // Read in phase two, process in phase three.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            operand_r <= 8'h00;
            result_r  <= 8'h00;
            equal_r   <= 1'b0;
        end else begin
            if (phase2) begin
                operand_r <= data_rdata_i;
            end
            if (phase3) begin
                result_r <= (op == core_subset_pkg::OP_REGISTER_CLEAR) ? 8'h00 : ~operand_r;
                // Unsigned difference of zero means equal; flags are left alone.
                equal_r  <= (operand_r - accum_r) == 8'h00;
            end else if (phase4) begin
                equal_r  <= 1'b0;
            end
        end
    end

    // Memory write strobe covers exactly the phase-four clock.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_we_r    <= 1'b0;
            data_wdata_r <= 8'h00;
        end else begin
            data_we_r <= phase3 && (op == core_subset_pkg::OP_REGISTER_CLEAR ||
                         (op == core_subset_pkg::OP_REGISTER_COMPLEMENT && dest_bit));
            if (phase3) begin
                data_wdata_r <= (op == core_subset_pkg::OP_REGISTER_CLEAR) ? 8'h00
                                                                           : ~operand_r;
            end
        end
    end

    // Accumulator and flags update in phase four; the compare never touches flags.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            accum_r <= 8'h00;
            flags_r <= 5'h00;
        end else if (bus_write && avs_address_i == core_subset_pkg::REG_CORE) begin
            accum_r <= avs_writedata_i[7:0];
            flags_r <= avs_writedata_i[12:8];
        end else if (phase4) begin
            if (op == core_subset_pkg::OP_REGISTER_CLEAR) begin
                flags_r[core_subset_pkg::FLAG_Z] <= 1'b1;
            end else if (op == core_subset_pkg::OP_REGISTER_COMPLEMENT) begin
                flags_r[core_subset_pkg::FLAG_N] <= result_r[7];
                flags_r[core_subset_pkg::FLAG_Z] <= result_r == 8'h00;
                if (!dest_bit) begin
                    accum_r <= result_r;
                end
            end
        end
    end

    // Bank select is software loaded; the instruction subset never changes it.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            bank_select_reg_r <= 4'h0;
        end else if (bus_write && avs_address_i == core_subset_pkg::REG_CORE) begin
            bank_select_reg_r <= avs_writedata_i[19:16];
        end
    end

    // Watchdog count steps once per instruction cycle and carries into the postscaler; no timeout action exists.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wdt_count_r <= 8'h00;
            wdt_post_r  <= 16'h0000;
        end else if (phase3 && op == core_subset_pkg::OP_WATCHDOG_CLEAR) begin
            wdt_count_r <= 8'h00;
            wdt_post_r  <= 16'h0000;
        end else if (phase4) begin
            wdt_count_r <= wdt_count_r + 8'h01;
            if (wdt_count_r == 8'hff) begin
                wdt_post_r <= wdt_post_r + 16'h0001;
            end
        end
    end

    // Active-low status flags; the instruction's set wins over a software clear.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            watchdog_expired_n_r <= 1'b1;
            sleep_entered_n_r    <= 1'b1;
        end else if (phase3 && op == core_subset_pkg::OP_WATCHDOG_CLEAR) begin
            watchdog_expired_n_r <= 1'b1;
            sleep_entered_n_r    <= 1'b1;
        end else if (bus_write && avs_address_i == core_subset_pkg::REG_WDT) begin
            watchdog_expired_n_r <= avs_writedata_i[core_subset_pkg::WDT_EXP_BIT];
            sleep_entered_n_r    <= avs_writedata_i[core_subset_pkg::WDT_SLP_BIT];
        end
    end

    // Software control: run, extended set enable and the index base.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r       <= core_subset_pkg::CTRL_RESET;
            index_base_r <= 12'h000;
        end else if (bus_write) begin
            if (avs_address_i == core_subset_pkg::REG_CTRL) begin
                ctrl_r <= avs_writedata_i[1:0];
            end
            if (avs_address_i == core_subset_pkg::REG_INDEX) begin
                index_base_r <= avs_writedata_i[11:0];
            end
        end
    end

    // One wait state: read data is captured on the first edge, the access ends on the second.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_r      <= 1'b0;
            readdata_r <= 32'h00000000;
        end else begin
            ack_r <= bus_req && !ack_r;
            if (avs_read_i && !ack_r) begin
                unique case (avs_address_i)
                    core_subset_pkg::REG_CTRL:   readdata_r <= {30'h0, ctrl_r};
                    core_subset_pkg::REG_PC:     readdata_r <= {11'h0, program_counter_r};
                    core_subset_pkg::REG_CORE:   readdata_r <= {12'h0, bank_select_reg_r,
                                                                3'h0, flags_r, accum_r};
                    core_subset_pkg::REG_SHADOW: readdata_r <= {12'h0, bank_select_shadow_r,
                                                                3'h0, flags_shadow_r,
                                                                accumulator_shadow_r};
                    core_subset_pkg::REG_STACK:  readdata_r <= {6'h0, stack_ptr_r, stack_top_r};
                    core_subset_pkg::REG_WDT:    readdata_r <= {6'h0, sleep_entered_n_r,
                                                                watchdog_expired_n_r,
                                                                wdt_post_r, wdt_count_r};
                    core_subset_pkg::REG_INDEX:  readdata_r <= {20'h0, index_base_r};
                    default:                     readdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    // Output drive.
    assign avs_waitrequest_o = bus_req && !ack_r;
    assign avs_readdata_o    = readdata_r;
    assign prog_addr_o       = program_counter_r;
    assign data_addr_o       = data_addr_r;
    assign data_wdata_o      = data_wdata_r;
    assign data_we_o         = data_we_r;

endmodule : cpu_instruction_subset_exec

/* File: verif/mem_model.sv */
// Program and banked data memory model facing the core.
`timescale 1ns/10ps
module mem_model (
    input  wire logic        clk_i,
    input  wire logic [20:0] prog_addr_i,
    output logic      [15:0] prog_data_o,
    input  wire logic [11:0] data_addr_i,
    output logic      [7:0]  data_rdata_o,
    input  wire logic [7:0]  data_wdata_i,
    input  wire logic        data_we_i
);
    logic [15:0] prog [1024];
    logic [7:0]  dmem [4096];
    // Reads are combinational; space past the array reads as no-op words.
    assign prog_data_o  = (prog_addr_i[20:11] == 10'h0) ? prog[prog_addr_i[10:1]] : 16'h0000;
    assign data_rdata_o = dmem[data_addr_i];
    // A write lands at the edge that ends its one-clock strobe.
    always @(posedge clk_i) begin
        if (data_we_i) begin
            dmem[data_addr_i] <= data_wdata_i;
        end
    end
endmodule : mem_model

/* File: verif/core_subset_asserts.sv */
// Port assertions for the instruction subset core.
`timescale 1ns/10ps
module core_subset_asserts (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [20:0] prog_addr_o,
    input wire logic [11:0] data_addr_o,
    input wire logic        data_we_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Both fire only once per four-phase cycle, so three quiet clocks follow.
    sequence s_we_quiet;
        !data_we_o [*3];
    endsequence
    sequence s_pc_quiet;
        $stable(prog_addr_o) [*3];
    endsequence
    a_we_spacing: assert property (data_we_o |=> s_we_quiet)
        else $error("data write strobe repeated within a cycle");
    a_we_addr: assert property (data_we_o |-> $stable(data_addr_o))
        else $error("data address moved during write");
    a_we_phase: assert property (data_we_o |=> $changed(prog_addr_o))
        else $error("data write not in the last phase");
    a_pc_even: assert property (prog_addr_o[0] == 1'b0)
        else $error("program address odd");
    a_pc_hold: assert property ($changed(prog_addr_o) |=> s_pc_quiet)
        else $error("program address moved within a cycle");
    a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
        else $error("request answered without wait state");
    a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered after one wait");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i > 4'h6 |-> avs_readdata_o == 32'h0) else $error("unmapped read not 0");
endmodule : core_subset_asserts
bind cpu_instruction_subset_exec core_subset_asserts i_core_subset_asserts (.ref_clk_i,
    .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .prog_addr_o, .data_addr_o, .data_we_o);

/* File: verif/tb_cpu_instruction_subset_exec.sv */
// Self-checking bench for the instruction subset core.
`timescale 1ns/10ps
module tb_cpu_instruction_subset_exec;
    typedef struct packed {logic [12:0] key; logic [31:0] exp;} row_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, q;
    logic        stall, we;
    logic [20:0] pa;
    logic [15:0] pd;
    logic [11:0] da;
    logic [7:0]  dr, dw;
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // Program: clear, complement, equal skip over a two-word invoke, branches, invoke.
    // The target writes a complement back, compares unequal and parks on an overflow branch.
    logic [15:0] prog_w [16] = '{16'h6b10, 16'h1c90, 16'h6320, 16'hed40, 16'hf000, 16'he005,
        16'h6a05, 16'he003, 16'h1f10, 16'h0000, 16'h0000, 16'he401, 16'h1f10, 16'h0004,
        16'hed40, 16'hf001};
    // Key bit 12 set means a data memory address, else a register index.
    row_s        rows [8] = '{'{13'h1010, 32'hff}, '{13'h1f90, 32'h13}, '{13'h1205, 32'h0},
        '{13'h1005, 32'h66}, '{13'h0004, 32'h00200020}, '{13'h0003, 32'h1cec},
        '{13'h0002, 32'h18ec}, '{13'h0009, 32'h0}};
    cpu_instruction_subset_exec i_cpu_instruction_subset_exec (.ref_clk_i(clk), .rst_n_i(rst_n),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(stall), .prog_addr_o(pa), .prog_data_i(pd),
        .data_addr_o(da), .data_rdata_i(dr), .data_wdata_o(dw), .data_we_o(we));
    mem_model i_mem_model (.clk_i(clk), .prog_addr_i(pa), .prog_data_o(pd),
        .data_addr_i(da), .data_rdata_o(dr), .data_wdata_i(dw), .data_we_i(we));
    // Free-running 50 MHz clock.
    always #10 clk = ~clk;
    // A hang ends the run well after the expected run of about 110 cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // One Avalon transfer; the request is held until waitrequest is sampled low.
    // Only the bench's cycle ceiling ends a wait that never finishes.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wd <= d;
        do begin
            @(posedge clk);
        end while (stall !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        for (int i = 0; i < 4096; i++) begin
            i_mem_model.dmem[i] = 8'h00;
            if (i < 1024) i_mem_model.prog[i] = (i < 16) ? prog_w[i] : 16'h0000;
        end
        i_mem_model.prog[10'h140] = 16'h1f10; // Complement written back to the register.
        i_mem_model.prog[10'h141] = 16'h6310; // Unequal compare must not skip.
        i_mem_model.prog[10'h142] = 16'he4ff; // Overflow branch to itself parks the core.
        i_mem_model.dmem[12'h010] = 8'h5a;
        i_mem_model.dmem[12'hf90] = 8'h13;
        i_mem_model.dmem[12'h020] = 8'hec;
        i_mem_model.dmem[12'h205] = 8'h77;
        i_mem_model.dmem[12'h005] = 8'h66;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // Pause, preset overflow, clear status flags, set index base, resume extended.
        bus(1'b1, core_subset_pkg::REG_CTRL, 32'h0);
        bus(1'b1, core_subset_pkg::REG_CORE, 32'h800);
        bus(1'b1, core_subset_pkg::REG_WDT, 32'h0);
        bus(1'b1, core_subset_pkg::REG_INDEX, 32'h200);
        bus(1'b1, core_subset_pkg::REG_CTRL, 32'h3);
        q = 32'h0;
        for (int n = 0; n < 100 && q[20:2] !== 19'h000a1; n++) begin
            bus(1'b0, core_subset_pkg::REG_PC, 32'h0);
        end
        check({11'h0, q[20:2], 2'b0}, 32'h284, "park address");
        foreach (rows[i]) begin
            if (rows[i].key[12]) begin
                check({24'h0, i_mem_model.dmem[rows[i].key[11:0]]}, rows[i].exp, "data");
            end else begin
                bus(1'b0, rows[i].key[3:0], 32'h0);
                check(q, rows[i].exp, "register");
            end
        end
        bus(1'b0, core_subset_pkg::REG_WDT, 32'h0);
        check(q & 32'h03000000, 32'h03000000, "status flags");
        $display("program run done");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, core_subset_pkg::REG_PC, 32'h0);
        check(q, 32'h0, "pc after reset");
        bus(1'b0, core_subset_pkg::REG_CTRL, 32'h0);
        check(q, 32'h1, "control after reset");
        $display("reset test done");
        results();
    end
endmodule : tb_cpu_instruction_subset_exec
